// File: core/dcm_regs.vh
// dcm_regs.vh: offsets, fields, reset values for the debug comparator data match block
// assumes a wishbone byte-address map with one register per 32-bit word
`ifndef DCM_REGS_VH
`define DCM_REGS_VH
// printed offsets are register indices; byte address is index times four
`define DCM_IDX_ADDR_HIGH   8'h29
`define DCM_IDX_ADDR_MID    8'h2a
`define DCM_IDX_ADDR_LOW    8'h2b
`define DCM_IDX_DATA_HIGH   8'h2c
`define DCM_IDX_DATA_LOW    8'h2d
`define DCM_IDX_MASK_HIGH   8'h2e
`define DCM_IDX_MASK_LOW    8'h2f
`define DCM_IDX_CTRL        8'h30
`define DCM_IDX_STATUS      8'h31
// control register fields
`define DCM_CTRL_VIEW_LSB   0
`define DCM_CTRL_ARM_BIT    2
`define DCM_CTRL_TAG_BIT    3
`define DCM_CTRL_RANGE_BIT  4
`define DCM_CTRL_EN_LSB     5
// view selector codes
`define DCM_VIEW_A          2'h0
`define DCM_VIEW_B          2'h1
`define DCM_VIEW_C          2'h2
`define DCM_VIEW_NONE       2'h3
// reset values
`define DCM_RST_BYTE        8'h00
`define DCM_RST_CTRL        8'h00
`define DCM_ADDR_W          18
`define DCM_DATA_W          16
`endif

// File: core/dcm_cmp_store.v
// dcm_cmp_store.v: compare address store for three comparators, one byte lane per access
// assumes writes come gated by the register slave; read data is registered
`timescale 1ns/1ps
`include "dcm_regs.vh"
module dcm_cmp_store (
  clk,
  rstn,
  wr_en,
  wr_sel,
  wr_lane,
  wr_data,
  rd_sel,
  rd_lane,
  rd_data,
  addr_a,
  addr_b,
  addr_c
);
  input  wire        clk;
  input  wire        rstn;
  input  wire        wr_en;
  input  wire [1:0]  wr_sel;
  input  wire [1:0]  wr_lane;
  input  wire [7:0]  wr_data;
  input  wire [1:0]  rd_sel;
  input  wire [1:0]  rd_lane;
  output reg  [7:0]  rd_data;
  output wire [17:0] addr_a;
  output wire [17:0] addr_b;
  output wire [17:0] addr_c;

  reg  [17:0] rd_word;

  // one compare word per comparator, each with its own single driver
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_cmp
      localparam [1:0] slot_id = g;
      reg [17:0] word_reg;
      always @(posedge clk) begin
        if (!rstn) begin
          word_reg <= {2'h0, `DCM_RST_BYTE, `DCM_RST_BYTE}; // R12
        end else if (wr_en && wr_sel == slot_id) begin
          case (wr_lane)
            2'h0:    word_reg[17:16] <= wr_data[1:0]; // R11
            2'h1:    word_reg[15:8]  <= wr_data;      // R11
            2'h2:    word_reg[7:0]   <= wr_data;      // R01
            default: word_reg        <= word_reg;
          endcase
        end
      end
    end
  endgenerate

  assign addr_a = g_cmp[0].word_reg;
  assign addr_b = g_cmp[1].word_reg;
  assign addr_c = g_cmp[2].word_reg;

  // selected comparator word for the read port
  always @* begin
    case (rd_sel)
      2'h0:    rd_word = g_cmp[0].word_reg;
      2'h1:    rd_word = g_cmp[1].word_reg;
      2'h2:    rd_word = g_cmp[2].word_reg;
      default: rd_word = 18'h00000;
    endcase
  end

  // read anytime; view none reads zero
  always @(posedge clk) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else if (rd_sel == `DCM_VIEW_NONE) begin
      rd_data <= 8'h00;
    end else begin
      case (rd_lane)
        2'h0:    rd_data <= {6'h00, rd_word[17:16]};
        2'h1:    rd_data <= rd_word[15:8];
        2'h2:    rd_data <= rd_word[7:0]; // R02
        default: rd_data <= 8'h00;
      endcase
    end
  end
endmodule // dcm_cmp_store

// File: core/dcm_top.v
// dcm_top.v: debug comparator address and data match with a classic wishbone slave
// assumes cpu address, data and access strobe are synchronous to clk
// Functional notes
// (R01) each low address compare bit gives the level address bits 7..0 must have to match.
// (R02) the low address compare byte reads at any time and is written only while not armed.
// (R03) a 16-bit data compare value is held as a high byte and a low byte for data bits 15..0.
// (R04) a data compare bit counts only when its mask bit is one.
// (R05) only comparator a has data compare and mask storage; b and c match on address only.
// (R06) comparator a compares data only while its tag select bit is clear.
// (R07) a mask bit of 0 lets any data bit match, a 1 requires equality with the compare bit.
// (R08) data compare and mask registers read only while the view selector is 00.
// (R09) data compare and mask writes are taken only with view 00 and the unit not armed.
// (R10) view selector 00 shows a, 01 shows b, 10 shows c, 11 shows none.
// (R11) high and mid compare bytes give address bits 17..16 and 15..8 of an 18-bit address.
// (R12) without range mode every address bit must equal its compare bit; all registers reset to zero.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`include "dcm_regs.vh"
module dcm_top (
  clk,
  rstn,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_dat_i,
  wb_sel_i,
  wb_dat_o,
  wb_ack_o,
  cpu_addr,
  cpu_data,
  cpu_valid,
  match_a,
  match_b,
  match_c,
  armed,
  tag_select
);
  input  wire        clk;
  input  wire        rstn;
  input  wire        wb_cyc_i;
  input  wire        wb_stb_i;
  input  wire        wb_we_i;
  input  wire [7:0]  wb_adr_i;
  input  wire [31:0] wb_dat_i;
  input  wire [3:0]  wb_sel_i;
  output reg  [31:0] wb_dat_o;
  output reg         wb_ack_o;
  input  wire [17:0] cpu_addr;
  input  wire [15:0] cpu_data;
  input  wire        cpu_valid;
  output reg         match_a;
  output reg         match_b;
  output reg         match_c;
  output reg         armed;
  output reg         tag_select;

  reg  [7:0]  ctrl_reg;
  reg  [15:0] data_cmp_reg;
  reg  [15:0] data_mask_reg;
  reg  [7:0]  rd_byte_reg;
  reg         rd_from_store_reg;
  reg         rd_pend_reg;

  wire [1:0]  view_sel  = ctrl_reg[`DCM_CTRL_VIEW_LSB+1:`DCM_CTRL_VIEW_LSB];
  wire        arm_bit   = ctrl_reg[`DCM_CTRL_ARM_BIT];
  wire        tag_bit   = ctrl_reg[`DCM_CTRL_TAG_BIT];
  wire        range_bit = ctrl_reg[`DCM_CTRL_RANGE_BIT];
  wire [2:0]  cmp_en    = ctrl_reg[`DCM_CTRL_EN_LSB+2:`DCM_CTRL_EN_LSB];

  wire [5:0]  idx      = wb_adr_i[7:2];
  wire [7:0]  reg_idx  = {2'h0, idx};
  wire        req      = wb_cyc_i && wb_stb_i && !wb_ack_o && !rd_pend_reg;
  wire        lane0    = wb_sel_i[0];
  wire        wr       = req && wb_we_i && lane0;
  wire        view_a   = (view_sel == `DCM_VIEW_A);                     // R10
  wire        data_wr_ok = wr && view_a && !arm_bit;                     // R09
  wire        is_addr  = (reg_idx == `DCM_IDX_ADDR_HIGH) || (reg_idx == `DCM_IDX_ADDR_MID) ||
                         (reg_idx == `DCM_IDX_ADDR_LOW);
  wire        addr_wr_ok = wr && is_addr && !arm_bit && (view_sel != `DCM_VIEW_NONE); // R02
  wire [1:0]  lane     = reg_idx[1:0] - 2'h1;

  wire [7:0]  store_rd;
  wire [17:0] addr_a;
  wire [17:0] addr_b;
  wire [17:0] addr_c;

  dcm_cmp_store u_store (
    .clk     (clk),
    .rstn    (rstn),
    .wr_en   (addr_wr_ok),
    .wr_sel  (view_sel),
    .wr_lane (lane),
    .wr_data (wb_dat_i[7:0]),
    .rd_sel  (view_sel),
    .rd_lane (lane),
    .rd_data (store_rd),
    .addr_a  (addr_a),
    .addr_b  (addr_b),
    .addr_c  (addr_c)
  );

  // register writes
  always @(posedge clk) begin
    if (!rstn) begin
      ctrl_reg      <= `DCM_RST_CTRL;                              // R12
      data_cmp_reg  <= {`DCM_RST_BYTE, `DCM_RST_BYTE};             // R12
      data_mask_reg <= {`DCM_RST_BYTE, `DCM_RST_BYTE};             // R12
    end else begin
      if (wr && reg_idx == `DCM_IDX_CTRL) begin
        ctrl_reg <= wb_dat_i[7:0];
      end
      if (data_wr_ok) begin
        case (reg_idx)
          `DCM_IDX_DATA_HIGH: data_cmp_reg[15:8]  <= wb_dat_i[7:0]; // R03
          `DCM_IDX_DATA_LOW:  data_cmp_reg[7:0]   <= wb_dat_i[7:0]; // R03
          `DCM_IDX_MASK_HIGH: data_mask_reg[15:8] <= wb_dat_i[7:0]; // R04
          `DCM_IDX_MASK_LOW:  data_mask_reg[7:0]  <= wb_dat_i[7:0]; // R04
          default:            data_cmp_reg        <= data_cmp_reg;
        endcase
      end
    end
  end

  // read mux for locally held registers
  reg [7:0] rd_local;
  always @* begin
    rd_local = 8'h00;
    case (reg_idx)
      `DCM_IDX_DATA_HIGH: rd_local = view_a ? data_cmp_reg[15:8]  : 8'h00; // R08
      `DCM_IDX_DATA_LOW:  rd_local = view_a ? data_cmp_reg[7:0]   : 8'h00; // R08
      `DCM_IDX_MASK_HIGH: rd_local = view_a ? data_mask_reg[15:8] : 8'h00; // R08
      `DCM_IDX_MASK_LOW:  rd_local = view_a ? data_mask_reg[7:0]  : 8'h00; // R08
      `DCM_IDX_CTRL:      rd_local = ctrl_reg;
      `DCM_IDX_STATUS:    rd_local = {5'h00, match_c, match_b, match_a};
      default:            rd_local = 8'h00;
    endcase
  end

  // slave handshake: writes ack next edge, reads ack two edges after the request
  always @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o          <= 1'b0;
      wb_dat_o          <= 32'h0000_0000;
      rd_pend_reg       <= 1'b0;
      rd_byte_reg       <= 8'h00;
      rd_from_store_reg <= 1'b0;
    end else begin
      wb_ack_o <= 1'b0;
      if (req && wb_we_i) begin
        wb_ack_o <= 1'b1;
      end else if (req) begin
        rd_pend_reg       <= 1'b1;
        rd_byte_reg       <= rd_local;
        rd_from_store_reg <= is_addr;
      end else if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        wb_ack_o    <= 1'b1;
        wb_dat_o    <= {24'h00_0000, rd_from_store_reg ? store_rd : rd_byte_reg};
      end
    end
  end

  // match logic
  wire addr_hit_a = (cpu_addr == addr_a); // R12
  wire addr_hit_b = (cpu_addr == addr_b); // R12
  wire addr_hit_c = (cpu_addr == addr_c); // R01
  wire data_hit_a = tag_bit | (((cpu_data ^ data_cmp_reg) & data_mask_reg) == 16'h0000); // R06 R07

  always @(posedge clk) begin
    if (!rstn) begin
      match_a    <= 1'b0;
      match_b    <= 1'b0;
      match_c    <= 1'b0;
      armed      <= 1'b0;
      tag_select <= 1'b0;
    end else begin
      match_a    <= cpu_valid && !range_bit && cmp_en[0] && addr_hit_a && data_hit_a; // R04
      match_b    <= cpu_valid && !range_bit && cmp_en[1] && addr_hit_b;               // R05
      match_c    <= cpu_valid && !range_bit && cmp_en[2] && addr_hit_c;               // R05
      armed      <= arm_bit;
      tag_select <= tag_bit;
    end
  end
endmodule // dcm_top

// File: verification/dcm_cpu_model.sv
// dcm_cpu_model.sv: cpu address and data bus as seen by the comparators
// assumes requests from the bench, launched one clock later
`timescale 1ns/1ps
module dcm_cpu_model (
  input  wire         clk,
  input  wire  [17:0] req_addr,
  input  wire  [15:0] req_data,
  input  wire         req_valid,
  output logic [17:0] cpu_addr = 18'h0,
  output logic [15:0] cpu_data = 16'h0,
  output logic        cpu_valid = 1'b0
);
  // idle bus toggles so stale values never match by luck
  always @(posedge clk) begin
    cpu_valid <= req_valid;
    cpu_addr  <= req_valid ? req_addr : ~cpu_addr;
    cpu_data  <= req_valid ? req_data : ~cpu_data;
  end
endmodule // dcm_cpu_model

// File: verification/dcm_assertions.sv
// dcm_assertions.sv: port checks on dcm_top
// assumes one clock, synchronous active-low rstn
`timescale 1ns/1ps
module dcm_assertions (
  input wire        clk,
  input wire        rstn,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        cpu_valid,
  input wire        match_a,
  input wire        match_b,
  input wire        match_c,
  input wire        armed,
  input wire        tag_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_write_ack_time: assert property ($rose(wb_cyc_i && wb_stb_i && wb_we_i) |=> wb_ack_o)
    else $error("write ack late");
  a_read_ack_time: assert property ($rose(wb_cyc_i && wb_stb_i && !wb_we_i) |=> !wb_ack_o ##1 wb_ack_o)
    else $error("read ack timing wrong");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
  a_match_a_valid: assert property (match_a |-> $past(cpu_valid)) else $error("match a without bus cycle");
  a_match_b_valid: assert property (match_b |-> $past(cpu_valid)) else $error("match b without bus cycle");
  a_match_c_valid: assert property (match_c |-> $past(cpu_valid)) else $error("match c without bus cycle");
  a_arm_by_write: assert property ($changed(armed) |-> $past(wb_ack_o) && $past(wb_we_i)) else $error("arm moved alone");
  a_tag_by_write: assert property ($changed(tag_select) |-> $past(wb_ack_o) && $past(wb_we_i)) else $error("tag moved");
endmodule // dcm_assertions
bind dcm_top dcm_assertions u_dcm_assertions (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
  .cpu_valid, .match_a, .match_b, .match_c, .armed, .tag_select);

// File: verification/debug_comparator_data_match_test.sv
// debug_comparator_data_match_test.sv: random and corner tests of dcm_top
// assumes wishbone byte map of index times four
`timescale 1ns/1ps
module debug_comparator_data_match_test;
  logic        clk = 0, rstn = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, p_valid = 0, tg;
  logic [7:0]  wb_adr = 8'h0;
  logic [31:0] wb_dat = 32'h0, wb_rdat, q;
  logic [3:0]  wb_sel = 4'h1;
  logic        wb_ack, cpu_valid, match_a, match_b, match_c, armed, tag_select;
  logic [17:0] p_addr = 18'h0, cpu_addr, a, ca [0:2];
  logic [15:0] p_data = 16'h0, cpu_data, d, cd = 16'h0, cm = 16'h0, x, y;
  int          error_cnt = 0, checked = 0, cycles = 0, c;
  initial forever #20 clk = ~clk;
  dcm_cpu_model u_dcm_cpu_model (.clk(clk), .req_addr(p_addr), .req_data(p_data), .req_valid(p_valid),
    .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_valid(cpu_valid));
  dcm_top u_dcm_top (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_valid(cpu_valid), .match_a(match_a), .match_b(match_b),
    .match_c(match_c), .armed(armed), .tag_select(tag_select));
  task finish_test;
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      error_cnt++;
      finish_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] dd);
    @(posedge clk);
    wb_cyc <= 1; wb_stb <= 1; wb_we <= w; wb_adr <= ad; wb_dat <= {24'h0, dd};
    do @(negedge clk); while (wb_ack !== 1'b1);
    @(posedge clk);
    q = wb_rdat;
    wb_cyc <= 0; wb_stb <= 0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dd); wb(1, ad, dd); endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e); wb(0, ad, 8'h0); chk(q, {24'h0, e}); endtask
  task automatic cpu(input logic [17:0] aa, input logic [15:0] dd, input logic v);
    @(posedge clk);
    p_addr <= aa; p_data <= dd; p_valid <= v;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic em(input int k, input logic [17:0] aa, input logic [15:0] dd, input logic v);
    em = v && aa === ca[k] && (k != 0 || tg || ((dd ^ cd) & cm) === 16'h0);
  endfunction
  initial begin
    void'($urandom(32'hacec6ce7));
    repeat (16) @(posedge clk);
    rstn <= 1;
    for (int i = 0; i < 10; i++) rd(8'ha4 + 8'h4 * i[7:0], 8'h0);
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h0);
    for (int v = 0; v < 3; v++) begin
      wr(8'hc0, v[7:0]);
      ca[v] = $urandom; x = $urandom; y = $urandom;
      wr(8'ha4, {6'h0, ca[v][17:16]}); wr(8'ha8, ca[v][15:8]); wr(8'hac, ca[v][7:0]);
      wr(8'hb0, x[15:8]); wr(8'hb4, x[7:0]); wr(8'hb8, y[15:8]); wr(8'hbc, y[7:0]);
      if (v == 0) begin cd = x; cm = y; end
      rd(8'hac, ca[v][7:0]); rd(8'ha4, {6'h0, ca[v][17:16]});
      rd(8'hb0, v == 0 ? cd[15:8] : 8'h0); rd(8'hbc, v == 0 ? cm[7:0] : 8'h0);
    end
    wr(8'hc0, 8'h03);
    rd(8'hac, 8'h0);
    for (int t = 0; t < 40; t++) begin
      tg = t >= 20;
      if (t % 20 == 0) wr(8'hc0, {3'h7, 1'b0, tg, 3'h0});
      c = $urandom_range(2, 0); a = t[0] ? ca[c] : 18'($urandom); d = $urandom;
      if (t[1]) d = (d & ~cm) | (cd & cm);
      cpu(a, d, t % 7 != 3);
      chk({match_c, match_b, match_a}, {em(2, a, d, t % 7 != 3), em(1, a, d, t % 7 != 3), em(0, a, d, t % 7 != 3)});
      chk(tag_select, tg);
    end
    wr(8'hc0, 8'hf0);
    cpu(ca[0], cd, 1);
    chk({match_c, match_b, match_a}, 3'h0);
    wr(8'hc0, 8'h24);
    @(negedge clk);
    chk(armed, 1'b1);
    wr(8'hac, ~ca[0][7:0]); wr(8'hb4, ~cd[7:0]);
    rd(8'hac, ca[0][7:0]);
    rd(8'hb4, cd[7:0]);
    cpu(ca[0], cd, 1);
    chk(match_a, 1'b1);
    cpu(ca[1], cd, 1);
    chk(match_b, 1'b0);
    cpu(ca[2], cd, 1);
    chk(match_c, 1'b0);
    @(posedge clk);
    rstn <= 0;
    repeat (4) @(posedge clk);
    rstn <= 1;
    rd(8'hac, 8'h0);
    rd(8'hb4, 8'h0);
    chk(armed, 1'b0);
    finish_test;
  end
endmodule // debug_comparator_data_match_test
